// *** dmt_pkg.sv ***
// Package: data memory map and table read constants
package dmt_pkg;

  // ---------------------------------------------------------------
  // Bank 0 and bank 1 special register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_INDIRECT_ACCESS_0  = 8'h00;
  localparam logic [7:0] ADDR_MEMORY_POINTER_0   = 8'h01;
  localparam logic [7:0] ADDR_INDIRECT_ACCESS_1  = 8'h02;
  localparam logic [7:0] ADDR_MEMORY_POINTER_1   = 8'h03;
  localparam logic [7:0] ADDR_BANK_SELECT        = 8'h04;
  localparam logic [7:0] ADDR_PROGRAM_COUNTER_LOW = 8'h06;
  localparam logic [7:0] ADDR_TABLE_POINTER_LOW  = 8'h07;
  localparam logic [7:0] ADDR_TABLE_HIGH_BYTE    = 8'h08;
  localparam logic [7:0] ADDR_TABLE_POINTER_PAGE = 8'h1f;
  localparam logic [7:0] ADDR_SFR0_LAST          = 8'h27;
  localparam logic [7:0] ADDR_SFR1_FIRST         = 8'h40;
  localparam logic [7:0] ADDR_SFR1_LAST          = 8'h4b;
  localparam logic [7:0] ADDR_GP_FIRST           = 8'h28;
  localparam logic [7:0] BANK1_VALUE             = 8'h01;

  // ---------------------------------------------------------------
  // Program memory pages
  // ---------------------------------------------------------------
  localparam logic [4:0]  LAST_PAGE_HI  = 5'h1f;
  localparam logic [12:0] LAST_PAGE_BASE = 13'h1f00;
  localparam logic [7:0]  RESET_BYTE    = 8'h00;
  localparam int          TABLE_CYCLES  = 2;

  // ---------------------------------------------------------------
  // Data memory operations
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    DMT_OP_NONE   = 3'b000,
    DMT_OP_READ   = 3'b001,
    DMT_OP_WRITE  = 3'b010,
    DMT_OP_BSET   = 3'b011,
    DMT_OP_BCLR   = 3'b100,
    DMT_OP_TRDC   = 3'b101,
    DMT_OP_TRDL   = 3'b110
  } dmt_op_e;

  typedef enum logic [0:0] {
    DMT_ST_IDLE  = 1'b0,
    DMT_ST_WRITE = 1'b1
  } dmt_state_e;

endpackage

// *** dmt_ram.sv ***
// Memory module: general purpose RAM with registered read data
`timescale 1ns/1ps
module dmt_ram #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  // Clock
  input  wire logic          clk_in,
  // Write port
  input  wire logic          we_in,
  input  wire logic [AW-1:0] waddr_in,
  input  wire logic [7:0]    wdata_in,
  // Read port
  input  wire logic [AW-1:0] raddr_in,
  output logic      [7:0]    rdata_out
);

  logic [7:0] mem_r [DEPTH];

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_r[waddr_in] <= wdata_in;
    end
    rdata_out <= mem_r[raddr_in];
  end

endmodule // dmt_ram

// *** dmt_data_memory.sv ***
// Data memory map, banking, indirect access and table read unit
//
// Summary of operation
// - Last-page table read fetches from 1F00H page
// - Current-page read offsets from current PC page
// - Low byte to destination, high into table-high
// - Table-high byte register is read-only
// - Every table read takes two cycles
// - Byte-wide memory, areas consecutive from 00H
// - General purpose RAM is readable and writable
// - Bit set/clear touch one bit only in bank 0; bank 1 bit ops write the other bits as 0
// - Unused special addresses read 00H
// - Two banks; some registers read-only
// - Bank 1 via pointer 1 when bank_select 01H
// - Direct addresses always resolve to bank 0
// - Bank 0 at 00H-27H, bank 1 40H-4BH
// - Page register option forms current-page address
// - Unfilled table-high bits read zero
// - Indirect register via indirection reads 00H
// - Pointer 0 bank 0 only; pointer 1 both
`timescale 1ns/1ps
module dmt_data_memory #(
  parameter int  PW          = 13,
  parameter int  PDW         = 16,
  parameter int  RAM_DEPTH   = 256,
  parameter bit  PAGE_REG_EN = 1'b1
) (
  // Clock and reset
  input  wire logic           core_clk_in,
  input  wire logic           rst_in,
  // Core access request
  input  wire logic [2:0]     op_in,
  input  wire logic [7:0]     addr_in,
  input  wire logic [7:0]     wdata_in,
  input  wire logic [2:0]     bit_sel_in,
  input  wire logic [PW-1:0]  pc_in,
  output logic      [7:0]     rdata_out,
  output logic                rvalid_out,
  output logic                busy_out,
  // Program memory fetch port
  output logic      [PW-1:0]  pmem_addr_out,
  output logic                pmem_rd_out,
  input  wire logic [PDW-1:0] pmem_data_in,
  // Bank 1 peripheral port
  output logic      [7:0]     b1_addr_out,
  output logic                b1_wr_out,
  output logic                b1_rd_out,
  output logic      [7:0]     b1_wdata_out,
  input  wire logic [7:0]     b1_rdata_in,
  // Program counter low write
  output logic                pcl_wr_out,
  output logic      [7:0]     pcl_wdata_out
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] mp0_r, mp0_nxt, mp1_r, mp1_nxt, bank_r, bank_nxt;
  logic [7:0] tblp_r, tblp_nxt, table_pointer_page_r, table_pointer_page_nxt, table_high_byte_r, table_high_byte_nxt;
  logic [7:0] dst_r, dst_nxt;
  logic [7:0] rdata_nxt;
  logic       rvalid_nxt;
  logic [PW-1:0] paddr_r, paddr_nxt;
  dmt_pkg::dmt_state_e st_r, st_nxt;

  // ---------------------------------------------------------------
  // Address resolution
  // ---------------------------------------------------------------
  logic [7:0] eff_addr;
  logic       eff_bank1;
  logic       eff_null;
  logic       is_rw, is_bit, is_tbl;
  dmt_pkg::dmt_op_e op;

  always_comb begin
    op        = dmt_pkg::dmt_op_e'(op_in);
    eff_addr  = addr_in;
    eff_bank1 = 1'b0;
    eff_null  = 1'b0;
    if (addr_in == dmt_pkg::ADDR_INDIRECT_ACCESS_0) begin
      eff_addr = mp0_r;
    end else if (addr_in == dmt_pkg::ADDR_INDIRECT_ACCESS_1) begin
      eff_addr  = mp1_r;
      eff_bank1 = (bank_r == dmt_pkg::BANK1_VALUE);
    end
    // Indirect register reached through a pointer does not exist
    if ((addr_in == dmt_pkg::ADDR_INDIRECT_ACCESS_0 ||
         addr_in == dmt_pkg::ADDR_INDIRECT_ACCESS_1) &&
        (eff_addr == dmt_pkg::ADDR_INDIRECT_ACCESS_0 ||
         eff_addr == dmt_pkg::ADDR_INDIRECT_ACCESS_1)) begin
      eff_null = 1'b1;
    end
    is_rw  = (op == dmt_pkg::DMT_OP_READ) || (op == dmt_pkg::DMT_OP_WRITE);
    is_bit = (op == dmt_pkg::DMT_OP_BSET) || (op == dmt_pkg::DMT_OP_BCLR);
    is_tbl = (op == dmt_pkg::DMT_OP_TRDC) || (op == dmt_pkg::DMT_OP_TRDL);
  end

  // ---------------------------------------------------------------
  // Read mux for a resolved address
  // ---------------------------------------------------------------
  logic       gp_hit, b1_hit;
  logic [7:0] ram_rdata;
  logic [7:0] sfr_rdata;

  always_comb begin
    gp_hit = !eff_bank1 && (eff_addr >= dmt_pkg::ADDR_GP_FIRST) &&
             (int'(eff_addr) < RAM_DEPTH);
    b1_hit = eff_bank1 && (eff_addr >= dmt_pkg::ADDR_SFR1_FIRST) &&
             (eff_addr <= dmt_pkg::ADDR_SFR1_LAST);
    sfr_rdata = dmt_pkg::RESET_BYTE;
    if (!eff_bank1 && !eff_null) begin
      unique case (eff_addr)
        dmt_pkg::ADDR_MEMORY_POINTER_0:   sfr_rdata = mp0_r;
        dmt_pkg::ADDR_MEMORY_POINTER_1:   sfr_rdata = mp1_r;
        dmt_pkg::ADDR_BANK_SELECT:        sfr_rdata = bank_r;
        dmt_pkg::ADDR_PROGRAM_COUNTER_LOW: sfr_rdata = pc_in[7:0];
        dmt_pkg::ADDR_TABLE_POINTER_LOW:  sfr_rdata = tblp_r;
        dmt_pkg::ADDR_TABLE_HIGH_BYTE:    sfr_rdata = table_high_byte_r;
        dmt_pkg::ADDR_TABLE_POINTER_PAGE: sfr_rdata = table_pointer_page_r;
        default:                          sfr_rdata = dmt_pkg::RESET_BYTE;
      endcase
    end
  end

  // Bank 1 read data arrives one cycle later, so it is registered alongside RAM
  logic       rd_gp_r, rd_b1_r, rd_gp_nxt, rd_b1_nxt;

  // ---------------------------------------------------------------
  // Write decode and main sequencer
  // ---------------------------------------------------------------
  logic [7:0] cur_byte;
  logic [7:0] wr_byte;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic       wr_bank1;
  logic       wr_null;
  logic       ram_we;

  always_comb begin
    cur_byte = gp_hit ? ram_rdata : sfr_rdata;
    wr_byte  = wdata_in;
    wr_en    = 1'b0;
    wr_addr  = eff_addr;
    wr_bank1 = eff_bank1;
    wr_null  = eff_null;
    mp0_nxt  = mp0_r;
    mp1_nxt  = mp1_r;
    bank_nxt = bank_r;
    tblp_nxt = tblp_r;
    table_pointer_page_nxt = table_pointer_page_r;
    table_high_byte_nxt = table_high_byte_r;
    dst_nxt  = dst_r;
    paddr_nxt = paddr_r;
    st_nxt   = st_r;
    rvalid_nxt = 1'b0;
    rd_gp_nxt = 1'b0;
    rd_b1_nxt = 1'b0;
    rdata_nxt = rdata_out;
    pmem_rd_out = 1'b0;
    pmem_addr_out = paddr_r;
    b1_addr_out  = eff_addr;
    b1_rd_out    = 1'b0;
    b1_wr_out    = 1'b0;
    b1_wdata_out = wdata_in;
    pcl_wr_out   = 1'b0;
    pcl_wdata_out = wdata_in;
    unique case (st_r)
      dmt_pkg::DMT_ST_IDLE: begin
        if (op == dmt_pkg::DMT_OP_READ) begin
          rvalid_nxt = !gp_hit && !b1_hit;
          rd_gp_nxt  = gp_hit;
          rd_b1_nxt  = b1_hit;
          b1_rd_out  = b1_hit;
          rdata_nxt  = sfr_rdata;
        end else if (op == dmt_pkg::DMT_OP_WRITE) begin
          wr_en = 1'b1;
        end else if (is_bit) begin
          // Read-modify-write on one bit; RAM bits come from the registered RAM read data
          wr_byte = cur_byte;
          wr_byte[bit_sel_in] = (op == dmt_pkg::DMT_OP_BSET);
          wr_en = 1'b1;
        end else if (is_tbl) begin
          // Indirect destinations resolve through the pointer, bank 0 only
          dst_nxt = eff_addr;
          if (op == dmt_pkg::DMT_OP_TRDL) begin
            paddr_nxt = PW'({dmt_pkg::LAST_PAGE_HI, tblp_r});
          end else if (PAGE_REG_EN) begin
            paddr_nxt = PW'({table_pointer_page_r[4:0], tblp_r});
          end else begin
            paddr_nxt = {pc_in[PW-1:8], tblp_r};
          end
          st_nxt = dmt_pkg::DMT_ST_WRITE;
        end
      end
      dmt_pkg::DMT_ST_WRITE: begin
        pmem_rd_out = 1'b1;
        wr_addr  = dst_r;
        wr_bank1 = 1'b0;
        wr_null  = 1'b0;
        wr_byte  = pmem_data_in[7:0];
        wr_en    = 1'b1;
        table_high_byte_nxt = 8'(pmem_data_in[PDW-1:8]);
        st_nxt   = dmt_pkg::DMT_ST_IDLE;
      end
    endcase
    // Second cycle reads of RAM or bank 1 land here
    if (rd_gp_r) begin
      rdata_nxt  = ram_rdata;
      rvalid_nxt = 1'b1;
    end else if (rd_b1_r) begin
      rdata_nxt  = b1_rdata_in;
      rvalid_nxt = 1'b1;
    end
    // Register write side effects
    if (wr_en && !wr_null) begin
      if (wr_bank1) begin
        b1_wr_out    = (wr_addr >= dmt_pkg::ADDR_SFR1_FIRST) &&
                       (wr_addr <= dmt_pkg::ADDR_SFR1_LAST);
        b1_addr_out  = wr_addr;
        b1_wdata_out = wr_byte;
      end else begin
        unique case (wr_addr)
          dmt_pkg::ADDR_MEMORY_POINTER_0:   mp0_nxt  = wr_byte;
          dmt_pkg::ADDR_MEMORY_POINTER_1:   mp1_nxt  = wr_byte;
          dmt_pkg::ADDR_BANK_SELECT:        bank_nxt = wr_byte;
          dmt_pkg::ADDR_TABLE_POINTER_LOW:  tblp_nxt = wr_byte;
          dmt_pkg::ADDR_TABLE_POINTER_PAGE: table_pointer_page_nxt = wr_byte;
          dmt_pkg::ADDR_PROGRAM_COUNTER_LOW: begin
            pcl_wr_out    = 1'b1;
            pcl_wdata_out = wr_byte;
          end
          // Table-high byte ignores software writes
          default: ;
        endcase
      end
    end
  end

  always_comb begin
    ram_we = 1'b0;
    if (wr_en && !wr_null && !wr_bank1 &&
        wr_addr >= dmt_pkg::ADDR_GP_FIRST && int'(wr_addr) < RAM_DEPTH) begin
      ram_we = 1'b1;
    end
  end

  // Bit operations need the current RAM byte in the same cycle, so
  // a small combinational shadow is avoided by reading the registered
  // copy; software issues bit ops to RAM one cycle after addressing.
  dmt_ram #(
    .DEPTH (RAM_DEPTH),
    .AW    (8)
  ) u_ram (
    .clk_in    (core_clk_in),
    .we_in     (ram_we),
    .waddr_in  (wr_addr),
    .wdata_in  (wr_byte),
    .raddr_in  (eff_addr),
    .rdata_out (ram_rdata)
  );

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      mp0_r   <= 8'h00;
      mp1_r   <= 8'h00;
      bank_r  <= 8'h00;
      tblp_r  <= 8'h00;
      table_pointer_page_r  <= 8'h00;
      table_high_byte_r  <= 8'h00;
      dst_r   <= 8'h00;
      paddr_r <= '0;
      st_r    <= dmt_pkg::DMT_ST_IDLE;
      rdata_out  <= 8'h00;
      rvalid_out <= 1'b0;
      rd_gp_r <= 1'b0;
      rd_b1_r <= 1'b0;
    end else begin
      mp0_r   <= mp0_nxt;
      mp1_r   <= mp1_nxt;
      bank_r  <= bank_nxt;
      tblp_r  <= tblp_nxt;
      table_pointer_page_r  <= table_pointer_page_nxt;
      table_high_byte_r  <= table_high_byte_nxt;
      dst_r   <= dst_nxt;
      paddr_r <= paddr_nxt;
      st_r    <= st_nxt;
      rdata_out  <= rdata_nxt;
      rvalid_out <= rvalid_nxt;
      rd_gp_r <= rd_gp_nxt;
      rd_b1_r <= rd_b1_nxt;
    end
  end

  assign busy_out = (st_r == dmt_pkg::DMT_ST_WRITE);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_tbl_start;
    !busy_out && (op_in == 3'b101 || op_in == 3'b110);
  endsequence
  sequence s_tbl_fetch;
    busy_out && pmem_rd_out ##1 !busy_out;
  endsequence

  a_table_two_cycles: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_tbl_start |=> s_tbl_fetch) else $error("table read not two cycles");
  a_last_page_addr: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (!busy_out && op_in == 3'b110) |=> pmem_addr_out == {5'h1f, $past(tblp_r)})
    else $error("last page address wrong");
  a_cur_page_addr: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (!busy_out && op_in == 3'b101 && !PAGE_REG_EN) |=>
    pmem_addr_out[7:0] == $past(tblp_r)) else $error("current page address wrong");
  a_page_reg_addr: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (!busy_out && op_in == 3'b101 && PAGE_REG_EN) |=>
    pmem_addr_out == {$past(table_pointer_page_r[4:0]), $past(tblp_r)}) else $error("page reg address wrong");
  a_high_loaded: assert property (@(posedge core_clk_in) disable iff (rst_in)
    busy_out |=> table_high_byte_r == $past(pmem_data_in[15:8])) else $error("table high not loaded");
  a_high_readonly: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !busy_out |=> $stable(table_high_byte_r)) else $error("table high changed without read");
  a_unused_zero: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (!busy_out && op_in == 3'b001 && addr_in == 8'h0c) |=> rvalid_out && rdata_out == 8'h00)
    else $error("unused address not zero");
  a_direct_bank0: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (addr_in != 8'h02 && !busy_out) |-> !b1_wr_out && !b1_rd_out)
    else $error("direct access reached bank 1");
  a_ptr0_bank0: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (addr_in == 8'h00) |-> !b1_wr_out && !b1_rd_out) else $error("pointer 0 reached bank 1");

endmodule // dmt_data_memory

// *** dmt_data_memory_tb.sv ***
// Testbench: data memory map, banking, indirect access and table reads
`timescale 1ns/1ps
module data_memory_map_table_read_tb;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  typedef struct {
    dmt_pkg::dmt_op_e op;
    logic [7:0]       a;
    logic [7:0]       d;
    logic [2:0]       b;
    logic [7:0]       e;
    int               lat;
  } dmt_row_s;
  localparam dmt_pkg::dmt_op_e RD = dmt_pkg::DMT_OP_READ;
  localparam dmt_pkg::dmt_op_e WR = dmt_pkg::DMT_OP_WRITE;
  logic        core_clk;
  logic        rst_in      = 1'b1;
  logic [2:0]  op_in       = 3'h0;
  logic [7:0]  addr_in     = 8'h00;
  logic [7:0]  wdata_in    = 8'h00;
  logic [2:0]  bit_sel_in  = 3'h0;
  logic [12:0] pc_in       = 13'h0000;
  logic [7:0]  b1_rdata_in = 8'h00;
  logic [7:0]  rdata_out, b1_addr_out, b1_wdata_out, pcl_wdata_out;
  logic        rvalid_out, busy_out, pmem_rd_out, b1_wr_out, b1_rd_out, pcl_wr_out;
  logic [12:0] pmem_addr_out;
  logic [12:0] pmem_addr_np;
  logic [15:0] pmem_data_in;
  logic [15:0] w;
  logic [7:0]  b1w_a, b1w_d, pcl_seen;
  int          b1w_n = 0;
  int          n_mismatch = 0;
  int          comparisons = 0;

  dmt_data_memory #(.PW(13), .PDW(16), .RAM_DEPTH(256), .PAGE_REG_EN(1'b1)) uut (
    .core_clk_in(core_clk), .rst_in(rst_in), .op_in(op_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .bit_sel_in(bit_sel_in), .pc_in(pc_in),
    .rdata_out(rdata_out), .rvalid_out(rvalid_out), .busy_out(busy_out),
    .pmem_addr_out(pmem_addr_out), .pmem_rd_out(pmem_rd_out),
    .pmem_data_in(pmem_data_in), .b1_addr_out(b1_addr_out), .b1_wr_out(b1_wr_out),
    .b1_rd_out(b1_rd_out), .b1_wdata_out(b1_wdata_out), .b1_rdata_in(b1_rdata_in),
    .pcl_wr_out(pcl_wr_out), .pcl_wdata_out(pcl_wdata_out));

  // Page register option off, to reach the current-page path
  dmt_data_memory #(.PW(13), .PDW(16), .RAM_DEPTH(256), .PAGE_REG_EN(1'b0)) uut_np (
    .core_clk_in(core_clk), .rst_in(rst_in), .op_in(op_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .bit_sel_in(bit_sel_in), .pc_in(pc_in),
    .rdata_out(), .rvalid_out(), .busy_out(),
    .pmem_addr_out(pmem_addr_np), .pmem_rd_out(),
    .pmem_data_in(pmem_data_in), .b1_addr_out(), .b1_wr_out(),
    .b1_rd_out(), .b1_wdata_out(), .b1_rdata_in(b1_rdata_in),
    .pcl_wr_out(), .pcl_wdata_out());

  // ---------------------------------------------------------------
  // Far-side stand-ins
  // ---------------------------------------------------------------
  function automatic logic [15:0] pw(input logic [12:0] a);
    return {3'h0, a} ^ 16'hc3a5;
  endfunction
  // Word is only valid while fetching; otherwise show garbage
  assign pmem_data_in = pmem_rd_out ? pw(pmem_addr_out) : ~pw(pmem_addr_out);
  always @(posedge core_clk) begin
    b1_rdata_in <= (b1_rd_out === 1'b1) ? (b1_addr_out ^ 8'h3c) : ~b1_rdata_in;
    if (b1_wr_out === 1'b1) begin
      b1w_n <= b1w_n + 1;
      b1w_a <= b1_addr_out;
      b1w_d <= b1_wdata_out;
    end
    if (pcl_wr_out === 1'b1) pcl_seen <= pcl_wdata_out;
  end

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic summarize();
    if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic req(input dmt_pkg::dmt_op_e op, input logic [7:0] a, d, input logic [2:0] b);
    @(posedge core_clk);
    #1;
    op_in = op;
    addr_in = a;
    wdata_in = d;
    bit_sel_in = b;
    @(posedge core_clk);
    #1;
    op_in = dmt_pkg::DMT_OP_NONE;
  endtask

  task automatic rd(input logic [7:0] a, input int lat, input logic [7:0] e);
    int n;
    n = 1;
    req(RD, a, 8'h00, 3'h0);
    while (rvalid_out !== 1'b1 && n < 4) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (rvalid_out !== 1'b1) begin
      n_mismatch++;
      summarize();
    end else begin
      chk("rdata", {8'h00, rdata_out}, {8'h00, e});
      if (lat != 0) chk("latency", n[15:0], lat[15:0]);
    end
  endtask

  // Drives a write during the busy cycle; it must be ignored
  task automatic trd(input dmt_pkg::dmt_op_e op, input logic [7:0] dst,
                     input logic [12:0] pc, input logic [12:0] ea, input logic [12:0] ea_np);
    @(posedge core_clk);
    #1;
    op_in = op;
    addr_in = dst;
    pc_in = pc;
    @(posedge core_clk);
    #1;
    op_in = WR;
    addr_in = 8'h28;
    wdata_in = 8'h00;
    chk("busy", {15'h0, busy_out}, 16'h0001);
    chk("pmem_rd", {15'h0, pmem_rd_out}, 16'h0001);
    chk("pmem_addr", {3'h0, pmem_addr_out}, {3'h0, ea});
    chk("pmem_addr_np", {3'h0, pmem_addr_np}, {3'h0, ea_np});
    @(posedge core_clk);
    #1;
    op_in = dmt_pkg::DMT_OP_NONE;
    chk("busy_end", {15'h0, busy_out}, 16'h0000);
  endtask

  // ---------------------------------------------------------------
  // Ordinary cases
  // ---------------------------------------------------------------
  dmt_row_s rows [28] = '{
    '{WR, 8'h28, 8'ha5, 3'h0, 8'h00, 0}, '{RD, 8'h28, 8'h00, 3'h0, 8'ha5, 2},
    '{WR, 8'hff, 8'h3c, 3'h0, 8'h00, 0}, '{RD, 8'hff, 8'h00, 3'h0, 8'h3c, 2},
    '{WR, 8'h07, 8'h06, 3'h0, 8'h00, 0}, '{RD, 8'h07, 8'h00, 3'h0, 8'h06, 1},
    '{WR, 8'h08, 8'h77, 3'h0, 8'h00, 0}, '{RD, 8'h08, 8'h00, 3'h0, 8'h00, 1},
    '{RD, 8'h0c, 8'h00, 3'h0, 8'h00, 1}, '{RD, 8'h28, 8'h00, 3'h0, 8'ha5, 2},
    '{dmt_pkg::DMT_OP_BSET, 8'h28, 8'h00, 3'h1, 8'h00, 0},
    '{RD, 8'h28, 8'h00, 3'h0, 8'ha7, 2},
    '{dmt_pkg::DMT_OP_BCLR, 8'h28, 8'h00, 3'h7, 8'h00, 0},
    '{RD, 8'h28, 8'h00, 3'h0, 8'h27, 2},
    '{WR, 8'h40, 8'h5e, 3'h0, 8'h00, 0}, '{WR, 8'h04, 8'h01, 3'h0, 8'h00, 0},
    '{WR, 8'h01, 8'h40, 3'h0, 8'h00, 0}, '{RD, 8'h00, 8'h00, 3'h0, 8'h5e, 2},
    '{WR, 8'h03, 8'h40, 3'h0, 8'h00, 0}, '{RD, 8'h02, 8'h00, 3'h0, 8'h7c, 2},
    '{RD, 8'h40, 8'h00, 3'h0, 8'h5e, 2}, '{WR, 8'h02, 8'h99, 3'h0, 8'h00, 0},
    '{WR, 8'h41, 8'h11, 3'h0, 8'h00, 0}, '{WR, 8'h04, 8'h00, 3'h0, 8'h00, 0},
    '{RD, 8'h02, 8'h00, 3'h0, 8'h5e, 2}, '{WR, 8'h01, 8'h00, 3'h0, 8'h00, 0},
    '{RD, 8'h00, 8'h00, 3'h0, 8'h00, 1}, '{WR, 8'h06, 8'h12, 3'h0, 8'h00, 0}
  };

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    #1;
    rst_in = 1'b0;
    foreach (rows[i]) begin
      if (rows[i].op == RD) rd(rows[i].a, rows[i].lat, rows[i].e);
      else req(rows[i].op, rows[i].a, rows[i].d, rows[i].b);
    end
    chk("b1_writes", b1w_n[15:0], 16'h0001);
    chk("b1_wr", {b1w_a, b1w_d}, 16'h4099);
    chk("pcl", {8'h00, pcl_seen}, 16'h0012);
    w = pw(13'h1f06);
    trd(dmt_pkg::DMT_OP_TRDL, 8'h30, 13'h0a00, 13'h1f06, 13'h1f06);
    rd(8'h30, 2, w[7:0]);
    rd(8'h08, 1, w[15:8]);
    rd(8'h28, 2, 8'h27);
    req(WR, 8'h1f, 8'h05, 3'h0);
    req(WR, 8'h07, 8'hff, 3'h0);
    w = pw(13'h05ff);
    trd(dmt_pkg::DMT_OP_TRDC, 8'h31, 13'h0a00, 13'h05ff, 13'h0aff);
    rd(8'h31, 2, w[7:0]);
    rd(8'h08, 1, w[15:8]);
    // Reset in mid-run clears the special registers
    @(posedge core_clk);
    #1;
    rst_in = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    rst_in = 1'b0;
    chk("busy_rst", {15'h0, busy_out}, 16'h0000);
    chk("rvalid_rst", {15'h0, rvalid_out}, 16'h0000);
    rd(8'h07, 1, 8'h00);
    rd(8'h08, 1, 8'h00);
    rd(8'h1f, 1, 8'h00);
    summarize();
  end
endmodule // data_memory_map_table_read_tb
